// >>> src/spi_baud_status_data.sv
// Serial port core: baud select, status flags, data register and bus slave
`timescale 1ns/1ps
`include "spi_consts.svh"
module spi_baud_status_data (
	// Clock, reset, enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// Write address and data
	input  wire logic [31:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// Write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// Read address and data
	input  wire logic [31:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Serial link
	output logic             sck_o,
	output logic             sck_oe,
	input  wire logic        sck_i,
	output logic             mosi_o,
	output logic             mosi_oe,
	input  wire logic        mosi_i,
	output logic             miso_o,
	output logic             miso_oe,
	input  wire logic        miso_i,
	input  wire logic        ss_n_i,
	// Interrupt
	output logic             irq
);
	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic             awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
	logic [1:0]       bresp_d, rresp_d;
	logic [31:0]      rdata_d;
	logic             wr_fire, rd_fire, wr_ok;
	logic [7:0]       ctrl_q, ctrl_d, baud_q, baud_d;
	spi_pkg::byte_t   tx_q, tx_d, rx_q, rx_d;
	logic             rc_q, rc_d, te_q, te_d, mf_q, mf_d;
	logic             arm_rc_q, arm_rc_d, arm_te_q, arm_te_d, arm_mf_q, arm_mf_d;
	spi_pkg::event_t  evt_q, evt_d, mask_q, mask_d, evt_set;
	logic             ss_prev_q, is_master;
	logic             mf_event, abort, load, rc_clr, rc_set, mf_clr;
	logic             evt_clr, sh_idle, sh_done, tick;
	spi_pkg::byte_t   sh_rx;
	logic             sh_sdo, sh_sck;
	logic [7:0]       status_val;
	logic             sck_oe_d, mosi_oe_d, miso_oe_d;

	// Register decode on a word address
	function automatic logic hit(input logic [31:0] a, input logic [3:0] idx);
		hit = (a[31:6] == 26'h0) && (a[5:2] == idx);
	endfunction

	// Register outputs drawn from the shifter's own flops
	assign sck_o  = sh_sck;
	assign mosi_o = sh_sdo;
	assign miso_o = sh_sdo;

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	assign wr_fire = awready && wready && awvalid && wvalid;
	assign rd_fire = arready && arvalid;
	assign wr_ok   = wr_fire && wstrb[0];

	// Status byte as software sees it
	assign status_val = {rc_q, 1'b0, te_q, mf_q, 4'h0};

	// Both write channels are taken together in one cycle, then the response
	always_comb begin
		awready_d = !awready && !bvalid && awvalid && wvalid;
		wready_d  = !wready && !bvalid && awvalid && wvalid;
		bvalid_d  = bvalid && !bready;
		bresp_d   = bresp;
		arready_d = !arready && !rvalid && arvalid;
		rvalid_d  = rvalid && !rready;
		rresp_d   = rresp;
		rdata_d   = rdata;
		if (wr_fire) begin
			bvalid_d = 1'b1;
			bresp_d  = (hit(awaddr, `IDX_CTRL) || hit(awaddr, `IDX_BAUD) ||
				hit(awaddr, `IDX_STATUS) || hit(awaddr, `IDX_DATA) ||
				hit(awaddr, `IDX_EVENT) || hit(awaddr, `IDX_MASK)) ?
				`RESP_OKAY : `RESP_SLVERR;
		end
		if (rd_fire) begin
			rvalid_d = 1'b1;
			rresp_d  = `RESP_OKAY;
			if (hit(araddr, `IDX_CTRL)) begin
				rdata_d = {24'h0, ctrl_q};
			end else if (hit(araddr, `IDX_BAUD)) begin
				rdata_d = {24'h0, baud_q};
			end else if (hit(araddr, `IDX_STATUS)) begin
				rdata_d = {24'h0, status_val};
			end else if (hit(araddr, `IDX_DATA)) begin
				rdata_d = {24'h0, rx_q};
			end else if (hit(araddr, `IDX_EVENT)) begin
				rdata_d = {29'h0, evt_q};
			end else if (hit(araddr, `IDX_MASK)) begin
				rdata_d = {29'h0, mask_q};
			end else begin
				rdata_d = 32'h0;
				rresp_d = `RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= `RESP_OKAY;
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rresp   <= `RESP_OKAY;
			rdata   <= 32'h0;
		end else if (ce) begin
			awready <= awready_d;
			wready  <= wready_d;
			bvalid  <= bvalid_d;
			bresp   <= bresp_d;
			arready <= arready_d;
			rvalid  <= rvalid_d;
			rresp   <= rresp_d;
			rdata   <= rdata_d;
		end
	end

	// ****************************************************************
	// Flags, buffers and control
	// ****************************************************************
	assign is_master = ctrl_q[`CTRL_MASTER];
	assign mf_event  = is_master && ctrl_q[`CTRL_MFEN] && ss_prev_q && !ss_n_i;
	// Any change of the divisor fields in master mode drops the frame
	assign abort     = mf_event || (is_master && wr_ok && hit(awaddr, `IDX_BAUD) &&
		((wdata[7:0] & `BAUD_WMASK) != baud_q));
	assign load      = !te_q && sh_idle && !abort;
	assign rc_clr    = rd_fire && hit(araddr, `IDX_DATA) && arm_rc_q;
	// A byte landing while the flag clears is still taken
	assign rc_set    = sh_done && (!rc_q || rc_clr);
	assign mf_clr    = wr_ok && hit(awaddr, `IDX_CTRL) && arm_mf_q;
	assign evt_clr   = rd_fire && hit(araddr, `IDX_EVENT);
	assign evt_set   = {mf_event, load, rc_set};

	// Status register has no write path at all
	always_comb begin
		ctrl_d   = ctrl_q;
		baud_d   = baud_q;
		tx_d     = tx_q;
		rx_d     = rx_q;
		te_d     = te_q;
		mask_d   = mask_q;
		arm_rc_d = arm_rc_q;
		arm_te_d = arm_te_q;
		arm_mf_d = arm_mf_q;
		if (wr_ok && hit(awaddr, `IDX_CTRL)) begin
			ctrl_d = wdata[7:0] & `CTRL_WMASK;
		end
		if (wr_ok && hit(awaddr, `IDX_BAUD)) begin
			baud_d = wdata[7:0] & `BAUD_WMASK;
		end
		if (wr_ok && hit(awaddr, `IDX_MASK)) begin
			mask_d = wdata[2:0];
		end
		if (mf_event) begin
			ctrl_d[`CTRL_MASTER] = 1'b0;
		end
		// A status read arms each clear sequence with what it returned
		if (rd_fire && hit(araddr, `IDX_STATUS)) begin
			arm_rc_d = rc_q;
			arm_te_d = te_q;
			arm_mf_d = mf_q;
		end
		if (rc_clr) begin
			arm_rc_d = 1'b0;
		end
		if (mf_clr) begin
			arm_mf_d = 1'b0;
		end
		// Unarmed data writes fall on the floor
		if (wr_ok && hit(awaddr, `IDX_DATA) && arm_te_q && te_q) begin
			tx_d     = wdata[7:0];
			te_d     = 1'b0;
			arm_te_d = 1'b0;
		end
		if (load) begin
			te_d = 1'b1;
		end
		if (rc_set) begin
			rx_d = sh_rx;
		end
	end

	assign rc_d = rc_set || (rc_q && !rc_clr);
	assign mf_d = mf_event || (mf_q && !mf_clr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q    <= `CTRL_RESET;
			baud_q    <= `BAUD_RESET;
			tx_q      <= 8'h00;
			rx_q      <= 8'h00;
			rc_q      <= 1'b0;
			te_q      <= 1'b1;
			mf_q      <= 1'b0;
			arm_rc_q  <= 1'b0;
			arm_te_q  <= 1'b0;
			arm_mf_q  <= 1'b0;
			mask_q    <= `EV_RESET;
			ss_prev_q <= 1'b1;
		end else if (ce) begin
			ctrl_q    <= ctrl_d;
			baud_q    <= baud_d;
			tx_q      <= tx_d;
			rx_q      <= rx_d;
			rc_q      <= rc_d;
			te_q      <= te_d;
			mf_q      <= mf_d;
			arm_rc_q  <= arm_rc_d;
			arm_te_q  <= arm_te_d;
			arm_mf_q  <= arm_mf_d;
			mask_q    <= mask_d;
			ss_prev_q <= ss_n_i;
		end
	end

	// ****************************************************************
	// Interrupt events and pin enables
	// ****************************************************************
	// Sticky event bits; a new event beats the read that clears it
	for (genvar i = 0; i < 3; i++) begin : g_evt
		assign evt_d[i] = evt_set[i] || (evt_q[i] && !evt_clr);
	end

	// Enables follow the mode; a slave drives its output only while selected
	always_comb begin
		sck_oe_d  = is_master;
		mosi_oe_d = is_master;
		miso_oe_d = !is_master && !ss_n_i;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			evt_q   <= `EV_RESET;
			irq     <= 1'b0;
			sck_oe  <= 1'b0;
			mosi_oe <= 1'b0;
			miso_oe <= 1'b0;
		end else if (ce) begin
			evt_q   <= evt_d;
			irq     <= |(evt_q & mask_q);
			sck_oe  <= sck_oe_d;
			mosi_oe <= mosi_oe_d;
			miso_oe <= miso_oe_d;
		end
	end

	// ****************************************************************
	// Engines
	// ****************************************************************
	baud_divider u_div (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ce        (ce),
		.run       (is_master && !sh_idle),
		.restart   (load || abort),
		.preselect (baud_q[`BAUD_PRE_LSB +: 3]),
		.select    (baud_q[`BAUD_SEL_LSB +: 3]),
		.tick_o    (tick)
	);

	byte_shifter u_shift (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ce        (ce),
		.master    (is_master),
		.abort     (abort),
		.load      (load),
		.tx_byte   (tx_q),
		.tick      (tick),
		.sck_i     (sck_i),
		.mosi_i    (mosi_i),
		.miso_i    (miso_i),
		.ss_n_i    (ss_n_i),
		.idle_o    (sh_idle),
		.done_o    (sh_done),
		.rx_byte_o (sh_rx),
		.sck_o     (sh_sck),
		.sdo_o     (sh_sdo)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	chk_rc_capture: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && sh_done && !rc_q |=> rc_q && (rx_q == $past(sh_rx)))
		else $error("received byte not captured with its flag");

	chk_rx_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && sh_done && rc_q && !rc_clr |=> rc_q && (rx_q == $past(rx_q)))
		else $error("unserviced byte overwritten");

	chk_tx_discard: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && wr_ok && hit(awaddr, `IDX_DATA) && !arm_te_q |=> (tx_q == $past(tx_q)))
		else $error("unarmed data write changed the transmit buffer");

	chk_mf_set: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && mf_event |=> mf_q && !ctrl_q[`CTRL_MASTER])
		else $error("mode fault did not flag and leave master mode");

	chk_reset_flags: assert property (@(posedge aclk)
		!aresetn |=> te_q && !rc_q && !mf_q)
		else $error("flags wrong after reset");

	chk_baud_abort: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && abort |=> sh_idle)
		else $error("divisor change did not idle the transfer");
endmodule

// >>> src/spi_consts.svh
// Register map, field positions, reset values and counts of the serial port block
`ifndef SPI_CONSTS_SVH
`define SPI_CONSTS_SVH

// Register indices; the byte address is four times the index
`define IDX_CTRL     4'h0
`define IDX_BAUD     4'h2
`define IDX_STATUS   4'h3
`define IDX_DATA     4'h5
`define IDX_EVENT    4'h6
`define IDX_MASK     4'h7

// Control register fields
`define CTRL_MASTER  0
`define CTRL_MFEN    1
`define CTRL_WMASK   8'h03
`define CTRL_RESET   8'h00

// Baud register fields
`define BAUD_PRE_LSB 4
`define BAUD_SEL_LSB 0
`define BAUD_WMASK   8'h77
`define BAUD_RESET   8'h00

// Status register bit positions
`define ST_RC        7
`define ST_TE        5
`define ST_MF        4

// Event and mask register bit positions
`define EV_RC        0
`define EV_TE        1
`define EV_MF        2
`define EV_RESET     3'h0

// Bus responses
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

// Frame counts and divisor bounds
`define HALF_LAST    4'hf
`define SLAVE_BITS   4'h8
`define DIV_MIN      12'h002
`define DIV_MAX      12'h800

`endif

// >>> src/spi_pkg.sv
// Types shared by the serial port block
package spi_pkg;
	typedef enum logic {SH_IDLE, SH_RUN} shift_state_e;
	typedef logic [7:0] byte_t;
	typedef logic [2:0] event_t;
endpackage

// >>> src/baud_divider.sv
// Serial clock half-period tick generator
`timescale 1ns/1ps
`include "spi_consts.svh"
module baud_divider (
	// Clock, reset, enable
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ce,
	// Control
	input  wire logic       run,
	input  wire logic       restart,
	input  wire logic [2:0] preselect,
	input  wire logic [2:0] select,
	// Half-period tick
	output logic            tick_o
);
	logic [10:0] half;
	logic [11:0] divisor;
	logic [10:0] cnt_q, cnt_d;
	logic        tick_d;

	// Divisor is (preselect+1) * 2^(select+1), so a half period is (preselect+1) << select
	assign half    = (11'(preselect) + 11'h001) << select;
	assign divisor = {half, 1'b0};

	// Count bus cycles; the first tick lands a half period after restart
	always_comb begin
		cnt_d  = cnt_q;
		tick_d = 1'b0;
		if (!run || restart) begin
			cnt_d = 11'h000;
		end else if (cnt_q == half - 11'h001) begin
			cnt_d  = 11'h000;
			tick_d = 1'b1;
		end else begin
			cnt_d = cnt_q + 11'h001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q  <= 11'h000;
			tick_o <= 1'b0;
		end else if (ce) begin
			cnt_q  <= cnt_d;
			tick_o <= tick_d;
		end
	end

	chk_divisor_bounds: assert property (@(posedge aclk) disable iff (!aresetn)
		(divisor >= `DIV_MIN) && (divisor <= `DIV_MAX) && (divisor[0] == 1'b0))
		else $error("serial clock divisor outside 2..2048");

	chk_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && run && !restart && tick_o && (half > 11'h001) |=> !tick_o)
		else $error("serial clock ticks closer than the divisor allows");
endmodule

// >>> src/byte_shifter.sv
// Eight-bit shift engine for master and slave transfers, clock phase zero
`timescale 1ns/1ps
`include "spi_consts.svh"
module byte_shifter (
	// Clock, reset, enable
	input  wire logic           aclk,
	input  wire logic           aresetn,
	input  wire logic           ce,
	// Control from the register side
	input  wire logic           master,
	input  wire logic           abort,
	input  wire logic           load,
	input  wire spi_pkg::byte_t tx_byte,
	input  wire logic           tick,
	// Serial pins, taken as synchronous inputs
	input  wire logic           sck_i,
	input  wire logic           mosi_i,
	input  wire logic           miso_i,
	input  wire logic           ss_n_i,
	// Status and data back
	output logic                idle_o,
	output logic                done_o,
	output spi_pkg::byte_t      rx_byte_o,
	output logic                sck_o,
	output logic                sdo_o
);
	spi_pkg::shift_state_e st_q, st_d;
	spi_pkg::byte_t        sreg_q, sreg_d;
	logic [3:0]            cnt_q, cnt_d;
	logic                  samp_q, samp_d;
	logic                  sck_d, done_d, prev_q;

	assign idle_o    = (st_q == spi_pkg::SH_IDLE) && (cnt_q == 4'h0);
	assign rx_byte_o = sreg_q;
	assign sdo_o     = sreg_q[7];

	// Sample on the rising edge, shift on the falling edge
	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		sreg_d = sreg_q;
		samp_d = samp_q;
		sck_d  = sck_o;
		done_d = 1'b0;
		if (abort) begin
			st_d  = spi_pkg::SH_IDLE;
			cnt_d = 4'h0;
			sck_d = 1'b0;
		end else if (master) begin
			case (st_q)
				spi_pkg::SH_IDLE: begin
					if (load) begin
						sreg_d = tx_byte;
						cnt_d  = 4'h0;
						st_d   = spi_pkg::SH_RUN;
					end
				end
				spi_pkg::SH_RUN: begin
					if (tick) begin
						sck_d = !sck_o;
						cnt_d = cnt_q + 4'h1;
						if (!sck_o) begin
							samp_d = miso_i;
						end else begin
							sreg_d = {sreg_q[6:0], samp_q};
						end
						if (cnt_q == `HALF_LAST) begin
							st_d   = spi_pkg::SH_IDLE;
							cnt_d  = 4'h0;
							done_d = 1'b1;
						end
					end
				end
				default: st_d = spi_pkg::SH_IDLE;
			endcase
		end else begin
			// Slave relies on the remote clock being no faster than the bus over four
			st_d  = spi_pkg::SH_IDLE;
			sck_d = 1'b0;
			if (ss_n_i) begin
				cnt_d = 4'h0;
			end else if (sck_i && !prev_q) begin
				samp_d = mosi_i;
				cnt_d  = cnt_q + 4'h1;
			end else if (!sck_i && prev_q && (cnt_q != 4'h0)) begin
				sreg_d = {sreg_q[6:0], samp_q};
				if (cnt_q == `SLAVE_BITS) begin
					cnt_d  = 4'h0;
					done_d = 1'b1;
				end
			end
			if (load && (cnt_q == 4'h0)) begin
				sreg_d = tx_byte;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q   <= spi_pkg::SH_IDLE;
			cnt_q  <= 4'h0;
			sreg_q <= 8'h00;
			samp_q <= 1'b0;
			sck_o  <= 1'b0;
			done_o <= 1'b0;
			prev_q <= 1'b0;
		end else if (ce) begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			sreg_q <= sreg_d;
			samp_q <= samp_d;
			sck_o  <= sck_d;
			done_o <= done_d;
			prev_q <= sck_i;
		end
	end

	chk_master_frame_end: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && master && !abort && (st_q == spi_pkg::SH_RUN) && tick && (cnt_q == `HALF_LAST)
		|=> done_o && idle_o)
		else $error("master frame did not end after sixteen half periods");
endmodule

// >>> tb/spi_slave_model.sv
// Remote serial slave that answers the core's master frames
`timescale 1ns/1ps
module spi_slave_model (
	// Clock and select from the bench
	input  wire logic        aclk,
	input  wire logic        sel,
	input  wire logic [7:0]  tx,
	// Serial link from the core
	input  wire logic        sck,
	input  wire logic        mosi,
	output logic             miso,
	// Last frame seen
	output logic [7:0]       rx_o,
	output logic [11:0]      half_o
);
	logic        sck_q = 1'b0;
	logic        tog_q = 1'b0;
	logic        inv_q = 1'b0;
	logic [2:0]  n_q   = 3'h0;
	logic [11:0] cnt_q = 12'h0;

	// Edge watch; each frame within one selection answers with the inverse of the one before
	always_ff @(posedge aclk) begin
		sck_q <= sck;
		tog_q <= ~tog_q;
		cnt_q <= cnt_q + 12'h1;
		if (sck != sck_q) begin
			half_o <= cnt_q + 12'h1;
			cnt_q  <= 12'h0;
		end
		if (sck && !sck_q)
			rx_o <= {rx_o[6:0], mosi};
		if (!sck && sck_q) begin
			n_q <= n_q + 3'h1;
			if (n_q == 3'h7)
				inv_q <= ~inv_q;
		end
		if (!sel) begin
			n_q   <= 3'h0;
			inv_q <= 1'b0;
		end
	end

	// Unselected line toggles, so a stale bit never passes for data
	// Next bit shows in the cycle a fall is seen; a one-cycle half period allows no lag
	assign miso = sel ? tx[3'h7 - n_q - {2'h0, !sck && sck_q}] ^ inv_q : tog_q;
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the serial port core
`timescale 1ns/1ps
`include "spi_consts.svh"
module testbench;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        bvalid, rvalid, awready, wready, arready, irq, sel;
	logic        sck_o, mosi_o, sck_i, mosi_i, miso_i, ss_n_i;
	logic        sck_oe, mosi_oe, miso_o, miso_oe;
	logic [1:0]  bresp, rresp;
	logic [3:0]  wstrb;
	logic [7:0]  tx, rx_o;
	logic [11:0] half_o;
	logic [31:0] awaddr, wdata, araddr, rdata, seed;
	logic [33:0] exp_q[$];
	logic [1:0]  bexp_q[$];
	int          mismatches, check_count;

	// Core with bus, link and interrupt all exercised
	spi_baud_status_data i_spi_baud_status_data (
		.aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .sck_o, .sck_oe, .sck_i, .mosi_o,
		.mosi_oe, .mosi_i, .miso_o, .miso_oe, .miso_i, .ss_n_i, .irq
	);

	// Remote slave on the master link
	spi_slave_model i_spi_slave_model (
		.aclk, .sel, .tx, .sck(sck_o), .mosi(mosi_o), .miso(miso_i), .rx_o, .half_o
	);

	// Clock, 8 ns period
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction

	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Write: both channels offered together, each released once taken
	task automatic wr(input logic [3:0] ix, input logic [7:0] d, input logic [1:0] e = 2'h0);
		logic a, w, ga, gw;
		a = 1'b0;
		w = 1'b0;
		bexp_q.push_back(e);
		@(posedge aclk);
		awaddr  <= {26'h0, ix, 2'h0};
		wdata   <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(negedge aclk);
			ga = awready;
			gw = wready;
			@(posedge aclk);
			if (ga) awvalid <= 1'b0;
			if (gw) wvalid <= 1'b0;
			a = a | ga;
			w = w | gw;
		end while (!(a && w));
		do @(negedge aclk); while (!bvalid);
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	// Read: expected word noted first, the monitor compares it
	task automatic rd(input logic [3:0] ix, input logic [7:0] d, input logic [1:0] e = 2'h0);
		@(posedge aclk);
		exp_q.push_back({e, 24'h0, d});
		araddr  <= {26'h0, ix, 2'h0};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (!rvalid);
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	// Response monitor; each handshake completes at the next rising edge
	always @(negedge aclk) begin
		if (rvalid && rready)
			chk("read word", exp_q.pop_front(), {rresp, rdata});
		if (bvalid && bready)
			chk("bresp", bexp_q.pop_front(), bresp);
	end

	task automatic wirq();
		int t;
		t = 0;
		do begin
			@(negedge aclk);
			t++;
		end while (!irq && t < 40000);
		chk("irq", 34'h1, irq);
	endtask

	// One master frame at a chosen divisor
	task automatic frame(input logic [2:0] p, input logic [2:0] s);
		logic [7:0] b, r;
		seed = xs(seed);
		b = seed[7:0];
		r = seed[15:8];
		sel <= 1'b0;
		tx  <= r;
		wr(`IDX_BAUD, {1'b0, p, 1'b0, s});
		sel <= 1'b1;
		rd(`IDX_STATUS, 8'h20);
		wr(`IDX_DATA, b);
		wirq();
		chk("sck enable", 34'h1, sck_oe);
		chk("mosi enable", 34'h1, mosi_oe);
		chk("half period", ({9'h0, p} + 12'h1) << s, half_o);
		chk("sent byte", b, rx_o);
		rd(`IDX_EVENT, 8'h03);
		rd(`IDX_STATUS, 8'ha0);
		rd(`IDX_DATA, r);
		rd(`IDX_STATUS, 8'h20);
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge aclk);
		mismatches++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		logic [31:0] q;
		int          i;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{sel, sck_i, mosi_i, tx, awaddr, wdata, araddr} = '0;
		ss_n_i = 1'b1;
		wstrb  = 4'hf;
		seed   = 32'h9fa1934a;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		wr(`IDX_DATA, 8'h55);
		rd(`IDX_STATUS, 8'h20);
		rd(`IDX_CTRL, 8'h00);
		rd(`IDX_BAUD, 8'h00);
		rd(`IDX_MASK, 8'h00);
		wr(`IDX_STATUS, 8'hff);
		rd(`IDX_STATUS, 8'h20);
		wr(4'hf, 8'h11, `RESP_SLVERR);
		rd(4'h1, 8'h00, `RESP_SLVERR);
		wr(`IDX_CTRL, 8'h01);
		wr(`IDX_MASK, 8'h01);
		rd(`IDX_EVENT, 8'h00);
		frame(3'h0, 3'h0);
		frame(3'h7, 3'h7);
		seed = xs(seed);
		frame(seed[2:0], {1'b0, seed[5:4]});
		// Second byte queued during the first frame, data left unserviced
		q = xs(seed);
		sel <= 1'b0;
		tx  <= q[23:16];
		wr(`IDX_BAUD, 8'h02);
		sel <= 1'b1;
		rd(`IDX_STATUS, 8'h20);
		wr(`IDX_DATA, q[7:0]);
		rd(`IDX_STATUS, 8'h20);
		wr(`IDX_DATA, q[15:8]);
		wirq();
		repeat (70) @(posedge aclk);
		chk("queued byte", q[15:8], rx_o);
		rd(`IDX_EVENT, 8'h03);
		rd(`IDX_STATUS, 8'ha0);
		rd(`IDX_DATA, q[23:16]);
		// Divisor change mid-frame
		sel <= 1'b0;
		wr(`IDX_BAUD, 8'h13);
		rd(`IDX_STATUS, 8'h20);
		wr(`IDX_DATA, 8'h5a);
		repeat (40) @(posedge aclk);
		wr(`IDX_BAUD, 8'h00);
		repeat (300) @(posedge aclk);
		chk("sck idle", 34'h0, sck_o);
		chk("masked irq", 34'h0, irq);
		rd(`IDX_STATUS, 8'h20);
		rd(`IDX_EVENT, 8'h02);
		// Mode fault and its clearing sequence
		wr(`IDX_MASK, 8'h04);
		wr(`IDX_CTRL, 8'h03);
		ss_n_i <= 1'b0;
		wirq();
		@(posedge aclk);
		ss_n_i <= 1'b1;
		rd(`IDX_STATUS, 8'h30);
		rd(`IDX_CTRL, 8'h02);
		chk("sck enable", 34'h0, sck_oe);
		wr(`IDX_CTRL, 8'h00);
		rd(`IDX_STATUS, 8'h20);
		rd(`IDX_EVENT, 8'h04);
		// Slave frame clocked by the bench, two cycles per level
		seed = xs(seed);
		@(posedge aclk);
		ss_n_i <= 1'b0;
		for (i = 0; i < 8; i++) begin
			mosi_i <= seed[7 - i];
			repeat (2) @(posedge aclk);
			sck_i <= 1'b1;
			repeat (2) @(posedge aclk);
			sck_i <= 1'b0;
		end
		repeat (4) @(posedge aclk);
		chk("miso enable", 34'h1, miso_oe);
		chk("miso bit", {33'h0, seed[7]}, miso_o);
		ss_n_i <= 1'b1;
		rd(`IDX_STATUS, 8'ha0);
		rd(`IDX_DATA, seed[7:0]);
		chk("miso enable", 34'h0, miso_oe);
		report_and_stop();
	end
endmodule
